// ### rtl/t8c_clksel.sv
// Purpose: timer clock tick generation from prescaler or count pin
// Assumes: count pin is asynchronous to clock
// Notes: tick is high one system clock cycle per count, so divide by one holds it high
`timescale 1ns/1ps
module t8c_clksel
    import t8c_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [CS_W-1:0] clk_sel,
    input wire logic ext_pin,
    output logic tick
);
    logic [PRE_W-1:0] pre_ff;
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic lvl_ff;
    logic ext_rise_ff;
    logic ext_fall_ff;

    wire logic agree = (sync2_ff == sync3_ff);
    wire logic nxt_lvl = agree ? sync3_ff : lvl_ff;
    wire logic tap8 = &pre_ff[TAP8-1:0];
    wire logic tap64 = &pre_ff[TAP64-1:0];
    wire logic tap256 = &pre_ff[TAP256-1:0];
    wire logic tap1024 = &pre_ff;

    // edges are registered so a tick is at most one cycle wide
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pre_ff <= '0;
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            lvl_ff <= 1'b0;
            ext_rise_ff <= 1'b0;
            ext_fall_ff <= 1'b0;
        end else begin
            pre_ff <= pre_ff + 1'b1;
            sync1_ff <= ext_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            lvl_ff <= nxt_lvl;
            ext_rise_ff <= nxt_lvl & ~lvl_ff;
            ext_fall_ff <= ~nxt_lvl & lvl_ff;
        end
    end

    always_comb begin
        case (t8c_cs_t'(clk_sel))
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = tap8;
            CS_DIV64: tick = tap64;
            CS_DIV256: tick = tap256;
            CS_DIV1024: tick = tap1024;
            CS_EXT_FALL: tick = ext_fall_ff;
            CS_EXT_RISE: tick = ext_rise_ff;
            default: tick = 1'b0;
        endcase
    end
endmodule // t8c_clksel

// ### rtl/t8c_pkg.sv
// Purpose: shared constants of the 8-bit timer/counter core
// Assumes: 32-bit classic wishbone register access, byte addresses
// Notes: one aligned word per register, data in the low byte
package t8c_pkg;
    localparam int ADR_W = 5;
    localparam logic [ADR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [ADR_W-1:0] OFF_CNT = 5'h04;
    localparam logic [ADR_W-1:0] OFF_CMP = 5'h08;
    localparam logic [ADR_W-1:0] OFF_FLAG = 5'h0C;
    localparam logic [ADR_W-1:0] OFF_MASK = 5'h10;

    // timer_control_reg layout
    localparam int CS_LSB = 0;
    localparam int CS_W = 3;
    localparam int WGM_LSB = 3;
    localparam int WGM_W = 2;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

    // timer_flag_reg / timer_mask_reg layout
    localparam int FLG_OVF = 0;
    localparam int FLG_CMP = 1;
    localparam int FLG_W = 2;
    localparam logic [FLG_W-1:0] FLG_RST = 2'h0;
    localparam logic [FLG_W-1:0] MASK_RST = 2'h0;

    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    typedef enum logic [1:0] {
        WGM_NORMAL = 2'b00,
        WGM_PHASE_PWM = 2'b01,
        WGM_CLEAR_ON_MATCH = 2'b10,
        WGM_FAST_PWM = 2'b11
    } t8c_wgm_t;

    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIV1 = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } t8c_cs_t;

    // prescaler tap widths: divide by 2**width
    localparam int PRE_W = 10;
    localparam int TAP8 = 3;
    localparam int TAP64 = 6;
    localparam int TAP256 = 8;
endpackage

// ### rtl/t8c_timer.sv
// Purpose: 8-bit timer/counter with one compare unit, wishbone registers
// Assumes: classic wishbone, one wait state, synchronous reset
// Notes: compare output pin actions are not part of this core
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - bottom status is high whenever the counter holds zero
// - max status is high whenever the counter holds 255
// - top is 255 or the compare value, chosen by waveform mode
// - counter and compare registers are both 8 bits wide
// - each flag is visible and gated by its own mask bit
// - ticks come from the prescaler or the external count pin
// - clock select zero stops the counter, no ticks
// - clock select field lives in the control register
// - compare continuously; a match sets the compare flag
// - compare writes land in a buffer before the comparator
// - software reads and writes the counter at any time
// - a counter write beats clear, increment and decrement
// - each tick clears, increments or decrements by one
// - two waveform mode bits in control choose the sequence
// - overflow flag set where the waveform mode defines it
// - internal count, direction, clear, top and bottom controls
// - normal mode wraps 255 to zero, overflow set that tick
// - mode 2 clears the counter on compare match
// - compare flag set on the tick after counter equals compare
// - a counter write blocks the match of the next tick
module t8c_timer
    import t8c_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic external_count_pin,
    output logic ovf_req,
    output logic cmp_req,
    output logic cnt_top,
    output logic cnt_bottom,
    output logic cnt_max
);
    logic [CTRL_W-1:0] ctrl_ff;
    logic [7:0] cnt_ff;
    logic [7:0] cmp_buf_ff;
    logic [7:0] cmp_act_ff;
    logic [FLG_W-1:0] flag_ff;
    logic [FLG_W-1:0] mask_ff;
    logic dir_ff;
    logic block_ff;
    logic ack_ff;
    logic [7:0] rdat_ff;
    logic [7:0] nxt_cnt;
    logic nxt_dir;
    logic [7:0] nxt_rdat;
    logic tick;

    // bus decode
    wire logic bus_req = wb_cyc_i & wb_stb_i;
    wire logic bus_new = bus_req & ~ack_ff;
    wire logic wr_lo = bus_req & ack_ff & wb_we_i & wb_sel_i[0];
    wire logic hit_ctrl = (wb_adr_i == OFF_CTRL);
    wire logic hit_cnt = (wb_adr_i == OFF_CNT);
    wire logic hit_cmp = (wb_adr_i == OFF_CMP);
    wire logic hit_flag = (wb_adr_i == OFF_FLAG);
    wire logic hit_mask = (wb_adr_i == OFF_MASK);
    wire logic ctrl_wr = wr_lo & hit_ctrl;
    wire logic cnt_wr = wr_lo & hit_cnt;
    wire logic cmp_wr = wr_lo & hit_cmp;
    wire logic flag_wr = wr_lo & hit_flag;
    wire logic mask_wr = wr_lo & hit_mask;

    // control fields
    wire logic [CS_W-1:0] clock_select_field = ctrl_ff[CS_LSB +: CS_W];
    wire logic [WGM_W-1:0] waveform_mode_field = ctrl_ff[WGM_LSB +: WGM_W];
    wire logic waveform_mode_hi = waveform_mode_field[1];
    wire logic waveform_mode_lo = waveform_mode_field[0];
    wire logic clear_on_match_mode = waveform_mode_hi & ~waveform_mode_lo;
    wire logic phase_mode = ~waveform_mode_hi & waveform_mode_lo;
    wire logic pwm_mode = waveform_mode_lo;

    // counter status
    wire logic at_bottom = (cnt_ff == CNT_BOTTOM);
    wire logic at_max = (cnt_ff == CNT_MAX);
    wire logic [7:0] top_val = clear_on_match_mode ? cmp_act_ff : CNT_MAX;
    wire logic at_top = (cnt_ff == top_val);
    wire logic match = (cnt_ff == cmp_act_ff);

    // internal counter controls
    wire logic count_dn = phase_mode & (dir_ff | at_max) & ~at_bottom;
    wire logic cnt_clear = clear_on_match_mode & match;
    wire logic count = tick & ~cnt_wr;

    // flag events
    wire logic ovf_up = ~phase_mode & at_max;
    wire logic ovf_pc = phase_mode & at_bottom & dir_ff;
    wire logic set_ovf = count & (ovf_up | ovf_pc);
    wire logic set_cmp = tick & match & ~block_ff;
    wire logic [FLG_W-1:0] flag_set = {set_cmp, set_ovf};
    wire logic [FLG_W-1:0] flag_clr = flag_wr ? wb_dat_i[FLG_W-1:0] : '0;
    wire logic [FLG_W-1:0] nxt_flag = (flag_ff & ~flag_clr) | flag_set;

    // non-pwm modes pass the buffer straight on; pwm waits for top
    wire logic cmp_load = ~pwm_mode | (tick & at_top);

    t8c_clksel u_clksel (
        .clock(clock),
        .rst_n(rst_n),
        .clk_sel(clock_select_field),
        .ext_pin(external_count_pin),
        .tick(tick)
    );

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        if (cnt_wr) begin
            nxt_cnt = wb_dat_i[7:0];
        end else if (tick) begin
            if (cnt_clear) begin
                nxt_cnt = CNT_BOTTOM;
            end else if (count_dn) begin
                nxt_cnt = cnt_ff - 8'h01;
            end else begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end
        if (!phase_mode) begin
            nxt_dir = 1'b0;
        end else if (count) begin
            nxt_dir = count_dn;
        end
    end

    always_comb begin
        case (1'b1)
            hit_ctrl: nxt_rdat = {{(8-CTRL_W){1'b0}}, ctrl_ff};
            hit_cnt: nxt_rdat = cnt_ff;
            hit_cmp: nxt_rdat = cmp_buf_ff;
            hit_flag: nxt_rdat = {{(8-FLG_W){1'b0}}, flag_ff};
            hit_mask: nxt_rdat = {{(8-FLG_W){1'b0}}, mask_ff};
            default: nxt_rdat = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            rdat_ff <= 8'h00;
        end else begin
            ack_ff <= bus_new;
            if (bus_new) begin
                rdat_ff <= nxt_rdat;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RST;
            mask_ff <= MASK_RST;
            cmp_buf_ff <= CMP_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_ff <= wb_dat_i[CTRL_W-1:0];
            end
            if (mask_wr) begin
                mask_ff <= wb_dat_i[FLG_W-1:0];
            end
            if (cmp_wr) begin
                cmp_buf_ff <= wb_dat_i[7:0];
            end
        end
    end

    // a flag set by hardware wins over a software clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag_ff <= FLG_RST;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_ff <= CNT_RST;
            dir_ff <= 1'b0;
            cmp_act_ff <= CMP_RST;
            block_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            dir_ff <= nxt_dir;
            if (cmp_load) begin
                cmp_act_ff <= cmp_buf_ff;
            end
            if (cnt_wr) begin
                block_ff <= 1'b1;
            end else if (tick) begin
                block_ff <= 1'b0;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = {24'h000000, rdat_ff};
    assign ovf_req = flag_ff[FLG_OVF] & mask_ff[FLG_OVF];
    assign cmp_req = flag_ff[FLG_CMP] & mask_ff[FLG_CMP];
    assign cnt_top = at_top;
    assign cnt_bottom = at_bottom;
    assign cnt_max = at_max;

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_stop;
        clock_select_field == 3'b000 |-> !tick;
    endproperty
    a_stop: assert property (p_stop)
        else $error("tick while clock select is zero");

    property p_wrap;
        (waveform_mode_field == 2'b00) && tick && !cnt_wr && at_max
            |=> cnt_ff == 8'h00 && flag_ff[FLG_OVF];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("normal mode wrap without overflow");

    property p_ctc;
        (waveform_mode_field == 2'b10) && tick && !cnt_wr && match
            |=> cnt_ff == 8'h00;
    endproperty
    a_ctc: assert property (p_ctc)
        else $error("counter not cleared on match");

    property p_cmp_set;
        tick && match && !block_ff |=> flag_ff[FLG_CMP];
    endproperty
    a_cmp_set: assert property (p_cmp_set)
        else $error("compare flag not set after match");

    property p_block;
        cnt_wr ##1 (tick && !flag_ff[FLG_CMP]) |=> !flag_ff[FLG_CMP];
    endproperty
    a_block: assert property (p_block)
        else $error("match not blocked after counter write");

    property p_cpu_wr;
        cnt_wr |=> cnt_ff == $past(wb_dat_i[7:0]);
    endproperty
    a_cpu_wr: assert property (p_cpu_wr)
        else $error("counter write lost");

    property p_inc;
        (waveform_mode_field == 2'b00) && tick && !cnt_wr
            |=> cnt_ff == $past(cnt_ff) + 8'h01;
    endproperty
    a_inc: assert property (p_inc)
        else $error("normal mode did not add one");

    property p_rd_cnt;
        bus_new && !wb_we_i && hit_cnt |=> wb_ack_o && wb_dat_o[7:0] == $past(cnt_ff);
    endproperty
    a_rd_cnt: assert property (p_rd_cnt)
        else $error("counter read wrong");

    property p_stopped;
        !tick && !cnt_wr |=> $stable(cnt_ff);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter moved without tick");

    property p_blk_tick;
        block_ff && tick && !flag_wr |=> flag_ff[FLG_CMP] == $past(flag_ff[FLG_CMP]);
    endproperty
    a_blk_tick: assert property (p_blk_tick)
        else $error("compare flag moved on a blocked tick");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");

    property p_ack_resp;
        bus_new |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("request not answered");

    property p_pc_turn;
        (waveform_mode_field == 2'b01) && tick && !cnt_wr && at_max
            |=> cnt_ff == 8'hFE && dir_ff;
    endproperty
    a_pc_turn: assert property (p_pc_turn)
        else $error("phase correct did not turn at max");

    property p_pc_ovf;
        (waveform_mode_field == 2'b01) && tick && !cnt_wr && at_bottom && dir_ff
            |=> cnt_ff == 8'h01 && flag_ff[FLG_OVF];
    endproperty
    a_pc_ovf: assert property (p_pc_ovf)
        else $error("phase correct overflow missing at bottom");

    property p_cmp_hold;
        pwm_mode && !(tick && at_top) |=> $stable(cmp_act_ff);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold)
        else $error("pwm compare value changed away from top");

    property p_cmp_pass;
        !pwm_mode |=> cmp_act_ff == $past(cmp_buf_ff);
    endproperty
    a_cmp_pass: assert property (p_cmp_pass)
        else $error("buffer not passed on outside pwm");

    property p_flag_clr;
        flag_wr && wb_dat_i[FLG_CMP] && !set_cmp |=> !flag_ff[FLG_CMP];
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("compare flag not cleared by write of one");

    property p_ovf_keep;
        flag_ff[FLG_OVF] && !(flag_wr && wb_dat_i[FLG_OVF]) |=> flag_ff[FLG_OVF];
    endproperty
    a_ovf_keep: assert property (p_ovf_keep)
        else $error("overflow flag lost without a clear");

    property p_wr_no_ovf;
        cnt_wr && !flag_ff[FLG_OVF] |=> !flag_ff[FLG_OVF];
    endproperty
    a_wr_no_ovf: assert property (p_wr_no_ovf)
        else $error("overflow set in a counter write cycle");

    property p_ctc_up;
        (waveform_mode_field == 2'b10) && tick && !cnt_wr && !match
            |=> cnt_ff == $past(cnt_ff) + 8'h01;
    endproperty
    a_ctc_up: assert property (p_ctc_up)
        else $error("clear on match mode did not add one");
endmodule // t8c_timer

// ### testbench/timer8_counter_unit_tb.sv
// Purpose: self-checking bench of the 8-bit timer/counter core
// Assumes: classic wishbone single cycles, pin edges used as single ticks
// Notes: prescaler checks use a count window, the divider phase is unknown
`timescale 1ns/1ps
module timer8_counter_unit_tb
    import t8c_pkg::*;
;
    logic clock;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic pin = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [3:0] bsel = 4'hF;
    logic [31:0] dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, ovf_req, cmp_req, cnt_top, cnt_bottom, cnt_max;
    logic [31:0] rv;
    wire [31:0] st = {27'h0, ovf_req, cmp_req, cnt_top, cnt_bottom, cnt_max};
    int n_errors = 0;
    int comparisons = 0;
    int sh[1:5] = '{0, 3, 6, 8, 10};

    t8c_timer dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_count_pin(pin),
        .ovf_req(ovf_req), .cmp_req(cmp_req), .cnt_top(cnt_top),
        .cnt_bottom(cnt_bottom), .cnt_max(cnt_max));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    // one request; ack is sampled at the edge, data taken there, then released
    task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= bsel;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1, "no ack");
    endtask

    task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e, m);
    endtask

    // each pulse gives one rising and one falling pin edge, level held 8 clocks
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock);
            pin <= 1'b1;
            repeat (8) @(posedge clock);
            pin <= 1'b0;
            repeat (8) @(posedge clock);
        end
    endtask

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask

    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk(st, 32'h02, "status after reset");
        rd(OFF_CTRL, 32'h0, "ctrl reset");
        rd(OFF_CNT, 32'h0, "cnt reset");
        rd(OFF_CMP, 32'h0, "cmp reset");
        rd(OFF_FLAG, 32'h0, "flag reset");
        rd(OFF_MASK, 32'h0, "mask reset");
        wr(5'h14, 32'hFF);
        rd(5'h14, 32'h0, "unmapped");
        wr(OFF_CNT, 32'hFFFFFF5A);
        rd(OFF_CNT, 32'h5A, "cnt width");
        // a write without the low byte lane selected must leave the register alone
        bsel = 4'hE;
        wr(OFF_CMP, 32'h77);
        bsel = 4'hF;
        rd(OFF_CMP, 32'h0, "sel0 ignored");
        pulse(2);
        rd(OFF_CNT, 32'h5A, "stopped");
        done("reset");
        // control: waveform mode in [4:3], clock select in [2:0]
        wr(OFF_MASK, 32'h3);
        wr(OFF_CTRL, 32'h07);
        wr(OFF_CNT, 32'hFE);
        pulse(1);
        chk(st, 32'h05, "at max");
        pulse(1);
        rd(OFF_CNT, 32'h0, "wrap");
        rd(OFF_FLAG, 32'h1, "ovf normal");
        chk(st, 32'h12, "ovf req");
        wr(OFF_MASK, 32'h2);
        // the mask lands at the ack edge, so let it settle before looking
        @(posedge clock);
        chk(st, 32'h02, "ovf masked");
        wr(OFF_FLAG, 32'h1);
        rd(OFF_FLAG, 32'h0, "flag clear");
        wr(OFF_MASK, 32'h3);
        done("normal");
        wr(OFF_CMP, 32'h5);
        wr(OFF_CNT, 32'h5);
        wr(OFF_FLAG, 32'h3);
        pulse(1);
        rd(OFF_FLAG, 32'h0, "match blocked");
        rd(OFF_CNT, 32'h6, "increment");
        wr(OFF_CNT, 32'h4);
        pulse(1);
        rd(OFF_FLAG, 32'h0, "no early flag");
        pulse(1);
        rd(OFF_FLAG, 32'h2, "cmp flag");
        chk(st, 32'h08, "cmp req");
        wr(OFF_CTRL, 32'h06);
        pulse(1);
        rd(OFF_CNT, 32'h7, "falling pin");
        done("compare");
        wr(OFF_CTRL, 32'h17);
        wr(OFF_CMP, 32'h3);
        wr(OFF_FLAG, 32'h3);
        wr(OFF_CNT, 32'h2);
        pulse(1);
        chk(st, 32'h04, "top is cmp");
        pulse(1);
        rd(OFF_CNT, 32'h0, "clear on match");
        rd(OFF_FLAG, 32'h2, "flags mode 2");
        done("clear on match");
        wr(OFF_CTRL, 32'h0F);
        wr(OFF_FLAG, 32'h3);
        wr(OFF_CNT, 32'hFE);
        pulse(2);
        rd(OFF_CNT, 32'hFE, "down count");
        wr(OFF_CNT, 32'h1);
        pulse(2);
        rd(OFF_CNT, 32'h1, "turn at bottom");
        rd(OFF_FLAG, 32'h1, "ovf mode 1");
        done("phase correct");
        // the old compare value must stay active until the counter reaches top
        wr(OFF_CTRL, 32'h1F);
        wr(OFF_CMP, 32'h20);
        wr(OFF_FLAG, 32'h3);
        wr(OFF_CNT, 32'h1F);
        pulse(2);
        rd(OFF_FLAG, 32'h0, "buffered cmp");
        wr(OFF_CNT, 32'hFF);
        pulse(1);
        rd(OFF_FLAG, 32'h1, "ovf mode 3");
        wr(OFF_FLAG, 32'h3);
        wr(OFF_CNT, 32'h1F);
        pulse(2);
        rd(OFF_FLAG, 32'h2, "cmp updated");
        done("fast pwm");
        for (int c = 1; c <= 5; c++) begin
            wr(OFF_CTRL, 32'(c));
            wr(OFF_CNT, 32'h0);
            repeat (6 << sh[c]) @(posedge clock);
            bus(1'b0, OFF_CNT, 32'h0, rv);
            chk(32'(rv >= 32'h5 && rv <= 32'hA), 32'h1, "prescaled rate");
        end
        wr(OFF_CTRL, 32'h01);
        wr(OFF_CNT, 32'h80);
        bus(1'b0, OFF_CNT, 32'h0, rv);
        chk(32'(rv >= 32'h80 && rv <= 32'h85), 32'h1, "write while running");
        wr(OFF_CTRL, 32'h00);
        bus(1'b0, OFF_CNT, 32'h0, rv);
        repeat (20) @(posedge clock);
        rd(OFF_CNT, rv, "stop holds");
        done("clock select");
        end_of_test();
    end

    // the tests take about 8700 cycles
    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule // timer8_counter_unit_tb
